// ===== tzel_pkg.sv
`default_nettype none
package tzel_pkg;

	// Core clock and conversion timing. A remote zone converts for twice
	// the local time so a filter capacitor on the diode line can settle.
	localparam int CLK_MHZ             = 50;
	localparam int LOCAL_CONV_TIME_NS  = 40000;
	localparam int REMOTE_CONV_TIME_NS = 2 * LOCAL_CONV_TIME_NS;
	localparam int LOCAL_CONV_CYC      =
		(LOCAL_CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int REMOTE_CONV_CYC     =
		(REMOTE_CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W               = 12;
	localparam logic [TMR_W-1:0] LOCAL_CONV_LEN  = TMR_W'(LOCAL_CONV_CYC);
	localparam logic [TMR_W-1:0] REMOTE_CONV_LEN = TMR_W'(REMOTE_CONV_CYC);
	localparam logic [TMR_W-1:0] TMR_LAST        = 12'h001;

	// Cycles after reset release before the address strap is sampled.
	localparam logic [1:0] ADDR_SETTLE = 2'h3;

	// Control word layout.
	localparam int CTRL_W         = 5;
	localparam int CTRL_HALT_BIT  = 0;
	localparam int CTRL_MODE_BIT  = 1;
	localparam int CTRL_MASK_BIT  = 2;
	localparam int CTRL_DEPTH_LSB = 3;
	localparam int CTRL_DEPTH_MSB = 4;

	// Power-on limits, whole degrees in two's complement.
	localparam logic [7:0] LOCAL_UPPER_RST  = 8'h51;
	localparam logic [7:0] LOCAL_LOWER_RST  = 8'h4c;
	localparam logic [7:0] REMOTE_UPPER_RST = 8'h61;
	localparam logic [7:0] REMOTE_LOWER_RST = 8'h5c;

	// Consecutive conversions required for each depth code.
	localparam logic [2:0] DEPTH_CODE0 = 3'h1;
	localparam logic [2:0] DEPTH_CODE1 = 3'h2;
	localparam logic [2:0] DEPTH_CODE2 = 3'h4;
	localparam logic [2:0] DEPTH_CODE3 = 3'h6;

	typedef enum logic [1:0] {
		ZONE_R1  = 2'h0,
		ZONE_R2  = 2'h1,
		ZONE_LOC = 2'h2
	} tzel_zone_t;

	typedef enum logic [1:0] {
		SEQ_HALT = 2'h0,
		SEQ_CONV = 2'h1,
		SEQ_HOLD = 2'h2
	} tzel_seq_t;

	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] lower;
	} tzel_limit_t;

	typedef struct packed {
		logic [1:0] depth;
		logic       mask;
		logic       mode;
		logic       halt;
	} tzel_ctrl_t;

	typedef struct packed {
		logic rd_tgl;
		logic cfg_tgl;
	} tzel_link_t;

	typedef struct packed {
		logic [1:0]       addr_sync;
		logic [1:0]       addr_wait;
		logic             addr_lsb;
		logic [1:0]       busy_sync;
		logic [2:0]       rd_sync;
		logic [2:0]       cfg_sync;
		tzel_ctrl_t       ctrl;
		logic             halt_ent;
		tzel_limit_t [2:0] lim;
		tzel_seq_t        seq;
		tzel_zone_t       zone;
		logic [TMR_W-1:0] tmr;
		logic [2:0][7:0]  reading;
		logic [2:0]       cvalid;
		logic             alert_latch;
		logic             alert_oe;
	} tzel_state_t;

	typedef struct packed {
		logic       under_armed;
		logic [2:0] cnt;
		logic       flag;
		logic       evt;
	} tzel_filt_t;

	function automatic logic [2:0] tzel_depth(input logic [1:0] f);
		case (f)
			2'h0:    tzel_depth = DEPTH_CODE0;
			2'h1:    tzel_depth = DEPTH_CODE1;
			2'h2:    tzel_depth = DEPTH_CODE2;
			default: tzel_depth = DEPTH_CODE3;
		endcase
	endfunction

	function automatic logic [TMR_W-1:0] tzel_conv_len(input tzel_zone_t z);
		tzel_conv_len = (z == ZONE_LOC) ? LOCAL_CONV_LEN : REMOTE_CONV_LEN;
	endfunction

	function automatic tzel_zone_t tzel_next_zone(input tzel_zone_t z);
		case (z)
			ZONE_R1: tzel_next_zone = ZONE_R2;
			ZONE_R2: tzel_next_zone = ZONE_LOC;
			default: tzel_next_zone = ZONE_R1;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== tzel_zone_filter.sv
`default_nettype none
module tzel_zone_filter (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  conv_valid,
	input  wire logic [7:0]            reading,
	input  wire tzel_pkg::tzel_limit_t limit,
	input  wire logic [2:0]            depth,
	input  wire logic                  int_mode,
	input  wire logic                  clear_flag,
	input  wire logic                  halt_entry,
	output logic                       flag,
	output logic                       evt
);
	import tzel_pkg::*;

	tzel_filt_t s_q;
	tzel_filt_t s_d;
	logic       hit;
	logic [2:0] cnt_inc;

	assign hit = s_q.under_armed ?
		($signed(reading) < $signed(limit.lower)) :
		($signed(reading) > $signed(limit.upper));
	assign cnt_inc = s_q.cnt + 3'h1;

	// A clear and a qualifying event in one cycle leave the flag set.
	always_comb begin
		s_d     = s_q;
		s_d.evt = 1'b0;
		if (clear_flag)
			s_d.flag = 1'b0;
		if (halt_entry) begin
			s_d.cnt = 3'h0;
			if (int_mode)
				s_d.flag = 1'b0;
		end else if (conv_valid) begin
			if (!hit) begin
				s_d.cnt = 3'h0;
			end else if (cnt_inc >= depth) begin
				s_d.cnt = 3'h0;
				s_d.under_armed = !s_q.under_armed;
				s_d.evt = 1'b1;
				s_d.flag = int_mode ? 1'b1 : !s_q.under_armed;
			end else begin
				s_d.cnt = cnt_inc;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flag = s_q.flag;
	assign evt  = s_q.evt;

	property p_cnt_restart;
		@(posedge clk) disable iff (!rst_n)
		conv_valid && !halt_entry && !hit |=> s_q.cnt == 3'h0;
	endproperty
	a_cnt_restart: assert property (p_cnt_restart)
		else $error("filter count kept after a miss");

	property p_no_early;
		@(posedge clk) disable iff (!rst_n)
		conv_valid && !halt_entry && hit && cnt_inc < depth
		|=> !evt && s_q.cnt == $past(cnt_inc);
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("event before filter depth");

	property p_rearm;
		@(posedge clk) disable iff (!rst_n)
		evt |-> s_q.under_armed != $past(s_q.under_armed);
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("event without re-arming");

	property p_cmp_flag;
		@(posedge clk) disable iff (!rst_n)
		conv_valid && !halt_entry && hit && cnt_inc >= depth && !int_mode
		|=> evt && flag == !$past(s_q.under_armed);
	endproperty
	a_cmp_flag: assert property (p_cmp_flag)
		else $error("comparator flag does not follow crossing");

endmodule
`default_nettype wire

// ===== tzel_top.sv
// Notes on behaviour
// - Convert continuously; pause while bus addresses us.
// - Order: remote one, remote two, local.
// - Remote conversion takes twice local time.
// - Aborted conversion is redone, order continues.
// - Reset: running, comparator, unmasked, depth one.
// - Reset limits: local 81/76, remote 97/92.
// - Address strap sampled once after reset.
// - Mode bit: 0 comparator, 1 latched interrupt.
// - Comparator: over limit for depth sets flag.
// - Comparator: under lower limit for depth clears.
// - Comparator: shutdown leaves alert unchanged.
// - Interrupt: only reads or shutdown clear.
// - Interrupt: re-arm only after opposite crossing.
// - Every zone starts armed for over-limit.
// - Shutdown bit stops all conversions.
// - Register writes work during shutdown too.
// - Interrupt shutdown clears alert and flags.
// - No events while shut down.
// - Values are signed whole degrees.
// - Depth code: 1, 2, 4 or 6.
// - Event needs depth consecutive crossings.
// - Independent filter per zone.
// - Mask keeps alert inactive; flags update.
// - Interrupt: zone flags cleared by control word read.
`default_nettype none
module tzel_top (
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic                         link_clk,
	input  wire logic                         bus_addressed,
	input  wire logic                         reg_read_done,
	input  wire logic                         config_read_done,
	input  wire logic                         address_select_pin,
	input  wire logic                         ctrl_wr,
	input  wire logic [tzel_pkg::CTRL_W-1:0]  ctrl_wdata,
	input  wire logic                         lim_wr,
	input  wire tzel_pkg::tzel_zone_t         lim_zone,
	input  wire logic                         lim_upper_sel,
	input  wire logic [7:0]                   lim_wdata,
	input  wire logic [7:0]                   adc_value,
	output tzel_pkg::tzel_ctrl_t              ctrl_word,
	output logic                              slave_addr_lsb,
	output logic                              adc_run,
	output tzel_pkg::tzel_zone_t              adc_zone,
	output logic [2:0][7:0]                   zone_reading,
	output tzel_pkg::tzel_limit_t [2:0]       zone_limits,
	output logic [2:0]                        zone_event_flag,
	output logic                              alert_o,
	output logic                              alert_oe
);
	import tzel_pkg::*;

	logic [1:0]  rst_pipe;
	logic        rst_n;
	tzel_link_t  link_q;
	tzel_link_t  link_d;
	tzel_state_t s_q;
	tzel_state_t s_d;
	logic        busy;
	logic        rd_evt;
	logic        cfg_evt;
	logic [2:0]  zone_evt;
	logic [2:0]  depth_n;

	// Asynchronous assert, synchronous release of the core reset.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	// Read events become toggles on the link clock, so nothing here
	// needs an edge after the frame that carried the read.
	always_comb begin
		link_d = link_q;
		if (reg_read_done)
			link_d.rd_tgl = !link_q.rd_tgl;
		if (config_read_done)
			link_d.cfg_tgl = !link_q.cfg_tgl;
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn)
			link_q <= '0;
		else
			link_q <= link_d;
	end

	// Decoded crossings; only second and later stages are looked at.
	assign busy    = s_q.busy_sync[1];
	assign rd_evt  = s_q.rd_sync[2] ^ s_q.rd_sync[1];
	assign cfg_evt = s_q.cfg_sync[2] ^ s_q.cfg_sync[1];
	assign depth_n = tzel_depth(s_q.ctrl.depth);

	for (genvar g = 0; g < 3; g++) begin : g_zone
		tzel_zone_filter u_filt (
			.clk        (clk),
			.rst_n      (rst_n),
			.conv_valid (s_q.cvalid[g]),
			.reading    (s_q.reading[g]),
			.limit      (s_q.lim[g]),
			.depth      (depth_n),
			.int_mode   (s_q.ctrl.mode),
			.clear_flag (cfg_evt & s_q.ctrl.mode),
			.halt_entry (s_q.halt_ent),
			.flag       (zone_event_flag[g]),
			.evt        (zone_evt[g])
		);
	end

	// Next-state logic for synchronisers, control, sequencer and alert.
	always_comb begin
		s_d          = s_q;
		s_d.cvalid   = 3'h0;
		s_d.halt_ent = 1'b0;
		s_d.addr_sync = {s_q.addr_sync[0], address_select_pin};
		s_d.busy_sync = {s_q.busy_sync[0], bus_addressed};
		s_d.rd_sync   = {s_q.rd_sync[1:0], link_q.rd_tgl};
		s_d.cfg_sync  = {s_q.cfg_sync[1:0], link_q.cfg_tgl};

		if (s_q.addr_wait != ADDR_SETTLE) begin
			s_d.addr_wait = s_q.addr_wait + 2'h1;
			if (s_d.addr_wait == ADDR_SETTLE)
				s_d.addr_lsb = s_q.addr_sync[1];
		end

		if (ctrl_wr) begin
			s_d.ctrl.halt  = ctrl_wdata[CTRL_HALT_BIT];
			s_d.ctrl.mode  = ctrl_wdata[CTRL_MODE_BIT];
			s_d.ctrl.mask  = ctrl_wdata[CTRL_MASK_BIT];
			s_d.ctrl.depth = ctrl_wdata[CTRL_DEPTH_MSB:CTRL_DEPTH_LSB];
			s_d.halt_ent   = ctrl_wdata[CTRL_HALT_BIT] && !s_q.ctrl.halt;
		end
		if (lim_wr) begin
			if (lim_upper_sel)
				s_d.lim[lim_zone].upper = lim_wdata;
			else
				s_d.lim[lim_zone].lower = lim_wdata;
		end

		// Conversion sequencer. A reading only counts when its full
		// settling time has run without a bus access in between.
		case (s_q.seq)
			SEQ_HALT: begin
				if (!s_q.ctrl.halt) begin
					s_d.seq  = SEQ_CONV;
					s_d.zone = ZONE_R1;
					s_d.tmr  = tzel_conv_len(ZONE_R1);
				end
			end
			SEQ_CONV: begin
				if (s_q.ctrl.halt) begin
					s_d.seq = SEQ_HALT;
				end else if (busy) begin
					s_d.seq = SEQ_HOLD;
				end else if (s_q.tmr == TMR_LAST) begin
					s_d.reading[s_q.zone] = adc_value;
					s_d.cvalid[s_q.zone]  = 1'b1;
					s_d.zone = tzel_next_zone(s_q.zone);
					s_d.tmr  = tzel_conv_len(tzel_next_zone(s_q.zone));
				end else begin
					s_d.tmr = s_q.tmr - TMR_LAST;
				end
			end
			SEQ_HOLD: begin
				if (s_q.ctrl.halt) begin
					s_d.seq = SEQ_HALT;
				end else if (!busy) begin
					s_d.seq = SEQ_CONV;
					s_d.tmr = tzel_conv_len(s_q.zone);
				end
			end
			default: begin
				s_d.seq = SEQ_HALT;
			end
		endcase

		// The latch only matters in interrupt behaviour; in comparator
		// behaviour the pin simply follows the zone flags.
		if (!s_q.ctrl.mode) begin
			s_d.alert_latch = 1'b0;
		end else begin
			if (rd_evt)
				s_d.alert_latch = 1'b0;
			if (|zone_evt && !s_q.ctrl.halt)
				s_d.alert_latch = 1'b1;
			if (s_q.halt_ent)
				s_d.alert_latch = 1'b0;
		end

		s_d.alert_oe = (s_q.ctrl.mode ? s_d.alert_latch : |zone_event_flag)
			& !s_q.ctrl.mask;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q                 <= '0;
			s_q.lim[ZONE_R1]    <= '{REMOTE_UPPER_RST, REMOTE_LOWER_RST};
			s_q.lim[ZONE_R2]    <= '{REMOTE_UPPER_RST, REMOTE_LOWER_RST};
			s_q.lim[ZONE_LOC]   <= '{LOCAL_UPPER_RST, LOCAL_LOWER_RST};
		end else begin
			s_q <= s_d;
		end
	end

	// Open-drain alert: the pin is only ever pulled low.
	assign alert_o        = 1'b0;
	assign alert_oe       = s_q.alert_oe;
	assign ctrl_word      = s_q.ctrl;
	assign slave_addr_lsb = s_q.addr_lsb;
	assign adc_run        = (s_q.seq == SEQ_CONV);
	assign adc_zone       = s_q.zone;
	assign zone_reading   = s_q.reading;
	assign zone_limits    = s_q.lim;

	property p_halt_stops;
		@(posedge clk) disable iff (!rst_n)
		s_q.ctrl.halt |=> !adc_run;
	endproperty
	a_halt_stops: assert property (p_halt_stops)
		else $error("conversion running in shutdown");

	property p_bus_pause;
		@(posedge clk) disable iff (!rst_n)
		adc_run && busy |=> !adc_run && s_q.cvalid == 3'h0;
	endproperty
	a_bus_pause: assert property (p_bus_pause)
		else $error("conversion not suspended for bus");

	property p_start_r1;
		@(posedge clk) disable iff (!rst_n)
		s_q.seq == SEQ_HALT && !s_q.ctrl.halt
		|=> adc_run && s_q.zone == ZONE_R1 && s_q.tmr == REMOTE_CONV_LEN;
	endproperty
	a_start_r1: assert property (p_start_r1)
		else $error("sequence does not start at remote one");

	property p_r1_len;
		@(posedge clk) disable iff (!rst_n)
		s_q.cvalid[ZONE_R1]
		|-> s_q.zone == ZONE_R2 && s_q.tmr == REMOTE_CONV_LEN;
	endproperty
	a_r1_len: assert property (p_r1_len)
		else $error("remote two not started with remote length");

	property p_local_len;
		@(posedge clk) disable iff (!rst_n)
		s_q.cvalid[ZONE_R2]
		|-> s_q.zone == ZONE_LOC && s_q.tmr == LOCAL_CONV_LEN;
	endproperty
	a_local_len: assert property (p_local_len)
		else $error("local not started with local length");

	property p_redo;
		@(posedge clk) disable iff (!rst_n)
		s_q.seq == SEQ_HOLD && !busy && !s_q.ctrl.halt
		|=> adc_run && $stable(s_q.zone)
			&& s_q.tmr == tzel_conv_len(s_q.zone);
	endproperty
	a_redo: assert property (p_redo)
		else $error("aborted conversion not redone");

	property p_cmp_low_power_halt_bit;
		@(posedge clk) disable iff (!rst_n)
		!s_q.ctrl.mode && s_q.seq == SEQ_HALT |=> $stable(zone_event_flag);
	endproperty
	a_cmp_low_power_halt_bit: assert property (p_cmp_low_power_halt_bit)
		else $error("comparator state changed in shutdown");

	property p_int_low_power_halt_bit;
		@(posedge clk) disable iff (!rst_n)
		s_q.halt_ent && s_q.ctrl.mode
		|=> !alert_oe && zone_event_flag == 3'h0;
	endproperty
	a_int_low_power_halt_bit: assert property (p_int_low_power_halt_bit)
		else $error("shutdown did not clear interrupt state");

	property p_no_conv_halt;
		@(posedge clk) disable iff (!rst_n)
		s_q.seq == SEQ_HALT |-> s_q.cvalid == 3'h0;
	endproperty
	a_no_conv_halt: assert property (p_no_conv_halt)
		else $error("result delivered while halted");

	property p_mask;
		@(posedge clk) disable iff (!rst_n)
		s_q.ctrl.mask |=> !alert_oe;
	endproperty
	a_mask: assert property (p_mask)
		else $error("alert driven while masked");

	property p_read_clr;
		@(posedge clk) disable iff (!rst_n)
		s_q.ctrl.mode && rd_evt && zone_evt == 3'h0 |=> !alert_oe;
	endproperty
	a_read_clr: assert property (p_read_clr)
		else $error("read did not release alert");

	property p_strap_once;
		@(posedge clk) disable iff (!rst_n)
		s_q.addr_wait == ADDR_SETTLE |=> $stable(slave_addr_lsb);
	endproperty
	a_strap_once: assert property (p_strap_once)
		else $error("address strap sampled again");

	property p_cmp_follow;
		@(posedge clk) disable iff (!rst_n)
		!s_q.ctrl.mode |=> alert_oe == ($past(zone_event_flag) != 3'h0
			&& !$past(s_q.ctrl.mask));
	endproperty
	a_cmp_follow: assert property (p_cmp_follow)
		else $error("comparator alert does not follow the flags");

	property p_int_set;
		@(posedge clk) disable iff (!rst_n)
		s_q.ctrl.mode && !s_q.ctrl.halt && !s_q.ctrl.mask
		&& zone_evt != 3'h0 |=> alert_oe;
	endproperty
	a_int_set: assert property (p_int_set)
		else $error("latched alert not raised on event");

	property p_halt_quiet;
		@(posedge clk) disable iff (!rst_n)
		s_q.ctrl.mode && s_q.ctrl.halt |=> !alert_oe;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet)
		else $error("alert raised during shutdown");

endmodule
`default_nettype wire

// ===== tzel_top_dummy_guard.sv
`default_nettype none
`default_nettype wire

// ===== tzel_host_model.sv
`default_nettype none
module tzel_host_model (
	output logic link_clk,
	output logic bus_addressed,
	output logic reg_read_done,
	output logic config_read_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run;

	// The serial clock only toggles inside a frame, as a real host does.
	initial begin
		link_clk = 1'b0;
		bus_addressed = 1'b0;
		reg_read_done = 1'b0;
		config_read_done = 1'b0;
		run = 1'b0;
		forever begin
			#16;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end

	// One addressed transaction; a read ends with one strobe pulse.
	task automatic frame(input int len, input logic rd, input logic cfg);
		run = 1'b1;
		@(posedge link_clk) #1 bus_addressed = 1'b1;
		repeat (len) @(posedge link_clk);
		#1 reg_read_done = rd;
		config_read_done = cfg;
		@(posedge link_clk) #1 reg_read_done = 1'b0;
		config_read_done = 1'b0;
		bus_addressed = 1'b0;
		repeat (2) @(posedge link_clk);
		run = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== three_zone_thermal_event_logic_bench.sv
`default_nettype none
module three_zone_thermal_event_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tzel_pkg::*;
	logic              clk, rstn, strap, ctrl_wr, lim_wr, lim_upper_sel;
	wire               link_clk, bus_addressed, reg_rd, cfg_rd;
	logic [4:0]        ctrl_wdata;
	tzel_zone_t        lim_zone, adc_zone;
	logic [7:0]        lim_wdata, adc_value;
	logic [2:0][7:0]   vals, zone_reading;
	tzel_ctrl_t        ctrl_word;
	tzel_limit_t [2:0] zone_limits;
	logic [2:0]        flags;
	logic              addr_lsb, adc_run, alert_o, alert_oe;
	logic [15:0]       lfsr_q;
	int                failures, checked, n;

	tzel_top dut (.clk(clk), .rstn(rstn), .link_clk(link_clk),
		.bus_addressed(bus_addressed), .reg_read_done(reg_rd),
		.config_read_done(cfg_rd), .address_select_pin(strap),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .lim_wr(lim_wr),
		.lim_zone(lim_zone), .lim_upper_sel(lim_upper_sel),
		.lim_wdata(lim_wdata), .adc_value(adc_value),
		.ctrl_word(ctrl_word), .slave_addr_lsb(addr_lsb),
		.adc_run(adc_run), .adc_zone(adc_zone),
		.zone_reading(zone_reading), .zone_limits(zone_limits),
		.zone_event_flag(flags), .alert_o(alert_o), .alert_oe(alert_oe));
	tzel_host_model host (.link_clk(link_clk), .bus_addressed(bus_addressed),
		.reg_read_done(reg_rd), .config_read_done(cfg_rd));

	// Core clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// The converter returns the planned value of the zone it works on.
	always @(negedge clk) adc_value <= vals[adc_zone];

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		chk_val(16'(got), 16'(exp));
	endtask

	task automatic test_done();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Bounded wait for a converter state; running out ends the run.
	task automatic wait_run(input logic r, input tzel_zone_t z);
		int i;
		for (i = 0; i < 20000; i++) begin
			if (adc_run === r && adc_zone === z) break;
			@(negedge clk);
		end
		if (i == 20000) begin
			failures++;
			test_done();
		end
	endtask

	// Counts the cycles a zone stays selected, then lets results land.
	task automatic conv(input tzel_zone_t z, output int len);
		wait_run(1'b1, z);
		len = 0;
		while (adc_zone === z && len < 9000) begin
			@(negedge clk);
			len++;
		end
		// A zone that never ends is a hang and closes the run.
		if (len == 9000) begin
			failures++;
			test_done();
		end else begin
			repeat (3) @(negedge clk);
		end
	endtask

	task automatic wr_ctrl(input logic [4:0] d);
		ctrl_wr = 1'b1;
		ctrl_wdata = d;
		@(negedge clk);
		ctrl_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Local readings stay in 00h..3fh, below every local upper limit.
	task automatic rnd_local();
		lfsr_q = lfsr(lfsr_q);
		vals[2] = {2'h0, lfsr_q[5:0]};
	endtask

	initial begin
		{rstn, ctrl_wr, lim_wr, lim_upper_sel, ctrl_wdata} = '0;
		lim_zone = ZONE_R1;
		lim_wdata = 8'h00;
		failures = 0;
		checked = 0;
		strap = 1'b1;
		lfsr_q = 16'h03d2;
		vals = {8'h20, 8'hc9, 8'h70};
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		chk_val(16'(ctrl_word), 16'h0000);
		chk_val(zone_limits[0], 16'h615c);
		chk_val(zone_limits[1], 16'h615c);
		chk_val(zone_limits[2], 16'h514c);
		repeat (8) @(negedge clk);
		strap = 1'b0;
		$display("test reset done");
		// First round: order, lengths, signed readings, over event.
		rnd_local();
		conv(ZONE_R1, n);
		chk_val(16'(adc_zone), 16'h0001);
		chk_val(16'(zone_reading[0]), 16'h0070);
		chk_val({flags, alert_oe, alert_o}, 16'h0006);
		conv(ZONE_R2, n);
		// The previous call already spent three cycles of this zone.
		chk_cnt(n + 3, REMOTE_CONV_CYC);
		chk_val(16'(zone_reading[1]), 16'h00c9);
		chk_val(16'(flags), 16'h0001);
		conv(ZONE_LOC, n);
		chk_cnt(n + 3, LOCAL_CONV_CYC);
		chk_val(16'(zone_reading[2]), 16'(vals[2]));
		chk_val(16'(adc_zone), 16'h0000);
		$display("test order done");
		// Bus abort at a random point of a remote conversion.
		vals[0] = 8'h50;
		rnd_local();
		wait_run(1'b1, ZONE_R1);
		repeat (200 + lfsr_q[9:0]) @(negedge clk);
		fork
			host.frame(20, 1'b0, 1'b0);
		join_none
		wait_run(1'b0, ZONE_R1);
		conv(ZONE_R1, n);
		chk_cnt(n, REMOTE_CONV_CYC);
		chk_val({flags, alert_oe}, 16'h0000);
		chk_val(16'(addr_lsb), 16'h0001);
		$display("test abort done");
		// Latched mode: reads, re-arm and shutdown clearing.
		wr_ctrl(5'h02);
		vals[1] = 8'h70;
		conv(ZONE_R2, n);
		chk_val({flags, alert_oe}, 16'h0005);
		host.frame(4, 1'b1, 1'b0);
		repeat (10) @(negedge clk);
		chk_val({flags, alert_oe}, 16'h0004);
		conv(ZONE_R2, n);
		chk_val({flags, alert_oe}, 16'h0004);
		vals[1] = 8'h10;
		host.frame(4, 1'b1, 1'b1);
		repeat (10) @(negedge clk);
		chk_val({flags, alert_oe}, 16'h0000);
		conv(ZONE_R2, n);
		chk_val({flags, alert_oe}, 16'h0005);
		vals[0] = 8'h70;
		wr_ctrl(5'h03);
		chk_val({flags, alert_oe, adc_run}, 16'h0000);
		lim_wr = 1'b1;
		lim_zone = ZONE_LOC;
		lim_wdata = 8'h30;
		@(negedge clk);
		lim_wr = 1'b0;
		repeat (2) @(negedge clk);
		chk_val(zone_limits[2], 16'h5130);
		for (int d = 0; d < 4; d++) begin
			wr_ctrl({d[1:0], 3'h1});
			chk_val(16'(ctrl_word), 16'({d[1:0], 3'h1}));
		end
		repeat (3000) @(negedge clk);
		chk_val({flags, adc_run}, 16'h0000);
		$display("test latched done");
		// Comparator, depth two, masked, then shutdown holding alert.
		wr_ctrl(5'h0c);
		wait_run(1'b1, ZONE_R1);
		conv(ZONE_R1, n);
		// The write task let the first running cycle pass unseen.
		chk_cnt(n + 1, REMOTE_CONV_CYC);
		chk_val(16'(flags), 16'h0000);
		conv(ZONE_R1, n);
		chk_val({flags, alert_oe}, 16'h0002);
		wr_ctrl(5'h08);
		chk_val(16'(alert_oe), 16'h0001);
		wr_ctrl(5'h09);
		repeat (100) @(negedge clk);
		chk_val({flags, alert_oe, adc_run}, 16'h0006);
		wr_ctrl(5'h08);
		wait_run(1'b1, ZONE_R1);
		$display("test comparator done");
		test_done();
	end
endmodule
`default_nettype wire
